// File: hw/dcd_regs.vh
// Behaviour
// - sixteen 16-bit working registers, each usable as data, address or offset.
// - two 40-bit accumulators A and B, both DSP result targets.
// - shadow copies of registers 0 to SHD_N-1 move in one cycle; not addressable.
// - byte ops on a working register change only its low byte; bus reaches both bytes.
// - register 15 is the stack pointer, moved by push, pop, calls, returns, link and unlink.
// - stack grows upward; push writes then increments, pop decrements then reads.
// - register 14 is the frame pointer for link/unlink, still an ordinary register.
// - effective addresses are 16-bit byte addresses over a 64 KB space.
// - byte reads fetch the whole word; address bit 0 selects the byte.
// - post-increment advances by one for bytes, two for words.
// - word accesses at odd addresses raise the address error trap.
// - X space has separate read and write buses; MAC also reads Y concurrently.
// - bit-reversed addressing only on X writes; modulo addressing on X and Y.
// - 17x17 signed/unsigned multiplier giving 1.31 fractional or 32-bit integer result.
// - 40-bit adder sign-extends inputs; selected accumulator is source and destination.
// - add and load accumulator operands may be scaled by the barrel shifter.
// - overflow out of bit 39 latches that accumulator's catastrophic overflow flag.
// - guard overflow flag set while bits 32 to 39 are not all equal.
// - overflow flags show in the status register and may raise an arithmetic trap.
// - accumulator saturation clamps to 40-bit or 32-bit limits when enabled.
// - store-path saturation leaves the source accumulator unchanged.
// - accumulator store rounds to 1.15, conventional or convergent by mode.
// - without rounding the store truncates to 1.15, dropping the low word.
// - barrel shifter moves 40 bits left up to 31 or right up to 32 places in one cycle.
`ifndef DCD_REGS_VH
`define DCD_REGS_VH
`define DCD_CTRL_OFS      8'h00
`define DCD_STATUS_OFS    8'h04
`define DCD_MODSTART_OFS  8'h08
`define DCD_MODEND_OFS    8'h0C
`define DCD_BREVMOD_OFS   8'h10
`define DCD_ACCALO_OFS    8'h14
`define DCD_ACCAHI_OFS    8'h18
`define DCD_ACCBLO_OFS    8'h1C
`define DCD_ACCBHI_OFS    8'h20
`define DCD_WREG_BASE     8'h40
`define DCD_CTRL_RST      16'h0000
`define CTL_SATA    0
`define CTL_SATB    1
`define CTL_SAT32   2
`define CTL_STSAT   3
`define CTL_CONV    4
`define CTL_FRAC    5
`define CTL_CATTE   6
`define CTL_OVTE    7
`define CTL_MODEN   8
`define CTL_BREVEN  9
`define CTL_MULUS   10
`define ST_CATA     0
`define ST_CATB     1
`define ST_GRDA     2
`define ST_GRDB     3
`define ST_AERR     4
`define ST_BUSY     5
`define OP_LIT   4'h0
`define OP_LOAD  4'h1
`define OP_STORE 4'h2
`define OP_PUSH  4'h3
`define OP_POP   4'h4
`define OP_CALL  4'h5
`define OP_RET   4'h6
`define OP_LINK  4'h7
`define OP_UNLK  4'h8
`define OP_MAC   4'h9
`define OP_MPY   4'hA
`define OP_ADD   4'hB
`define OP_LAC   4'hC
`define OP_ASTR  4'hD
`define OP_SSAV  4'hE
`define OP_SRST  4'hF
`define SP_IDX   4'hF
`define FP_IDX   4'hE
`endif

// File: hw/dcd_core.v
`timescale 1ns/1ps
`default_nettype none
`include "dcd_regs.vh"
module dcd_core #(
  parameter SHD_N = 4
) (
  input  wire        sys_clk,
  input  wire        rst,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        op_valid,
  output wire        op_ready,
  input  wire [3:0]  op_code,
  input  wire [3:0]  op_dst,
  input  wire [3:0]  op_src,
  input  wire [3:0]  op_src2,
  input  wire        op_byte,
  input  wire        op_postinc,
  input  wire        op_accumulator_b,
  input  wire        op_sub,
  input  wire        op_round,
  input  wire [5:0]  op_shift,
  input  wire [15:0] op_lit,
  output reg         xr_en_q,
  output reg  [15:0] xr_addr_q,
  input  wire [15:0] xr_rdata,
  output reg         yr_en_q,
  output reg  [15:0] yr_addr_q,
  input  wire [15:0] yr_rdata,
  output reg         xw_en_q,
  output reg  [15:0] xw_addr_q,
  output reg  [15:0] xw_data_q,
  output reg  [1:0]  xw_be_q,
  output reg  [15:0] ret_addr_q,
  output reg         addr_err_trap_q,
  output reg         arith_err_trap_q
);
  localparam [1:0] S_IDLE = 2'b00;
  localparam [1:0] S_WAIT = 2'b01;
  localparam [1:0] S_TAKE = 2'b10;
  reg  [1:0]  state_q;
  reg  [15:0] ctrl_q;
  reg  [15:0] mod_start_q;
  reg  [15:0] mod_end_q;
  reg  [15:0] brev_mod_q;
  reg         cat_a_q;
  reg         cat_b_q;
  reg         aerr_q;
  reg  [39:0] accumulator_a;
  reg  [39:0] accumulator_b;
  reg  [15:0] shd_q [0:SHD_N-1];
  wire [15:0] w [0:15];
  wire [15:0] shd_w [0:15];
  reg  [3:0]  rd_op_q;
  reg  [3:0]  rd_dst_q;
  reg         rd_byte_q;
  reg         rd_hi_q;
  reg         rd_accumulator_b_q;
  reg         rd_sub_q;
  assign op_ready = (state_q == S_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // address helpers
  function [15:0] rev16;
    input [15:0] v;
    integer k;
    begin
      for (k = 0; k < 16; k = k + 1) begin
        rev16[k] = v[15-k];
      end
    end
  endfunction
  function [15:0] pinc;
    input [15:0] p;
    input [15:0] st;
    reg   [15:0] n;
    begin
      n = p + st;
      // circular buffer wraps once the pointer steps past the end
      if (ctrl_q[`CTL_MODEN] && p <= mod_end_q && n > mod_end_q) begin
        n = mod_start_q;
      end
      pinc = n;
    end
  endfunction

  wire [15:0] step  = op_byte ? 16'h0001 : 16'h0002;
  wire [15:0] sp    = w[`SP_IDX];
  wire [15:0] fp    = w[`FP_IDX];
  ////////////////////////////////////////////////////////////////////////////
  // dsp datapath
  reg         d_prod;
  reg         d_load;
  reg         d_accumulator_b;
  reg         d_sub;
  wire        in_take = (state_q == S_TAKE);
  wire [15:0] m_x = in_take ? xr_rdata : w[op_src];
  wire [15:0] m_y = in_take ? yr_rdata : w[op_src2];
  wire        us  = ctrl_q[`CTL_MULUS];
  wire signed [16:0] mx = {(~us & m_x[15]), m_x};
  wire signed [16:0] my = {(~us & m_y[15]), m_y};
  wire signed [33:0] prod = mx * my;
  wire [39:0] p40 = {{6{prod[33]}}, prod};
  wire [39:0] pscl = ctrl_q[`CTL_FRAC] ? {p40[38:0], 1'b0} : p40;
  wire [39:0] sh_in = {{8{w[op_src][15]}}, w[op_src], 16'h0000};
  wire [5:0]  sh_neg = 6'h00 - op_shift;
  // kept apart from the select so an unsigned branch cannot turn the right shift logical
  wire signed [39:0] sh_sr = $signed(sh_in) >>> sh_neg;
  wire [39:0] sh_out = op_shift[5] ? sh_sr : (sh_in << op_shift);
  wire [39:0] opnd = d_prod ? pscl : sh_out;
  wire [39:0] acc_src = d_accumulator_b ? accumulator_b : accumulator_a;
  wire [39:0] acc_base = d_load ? 40'h0000000000 : acc_src;
  wire [40:0] sum = d_sub ? ({acc_base[39], acc_base} - {opnd[39], opnd})
                          : ({acc_base[39], acc_base} + {opnd[39], opnd});
  wire        cat_ov = sum[40] ^ sum[39];
  wire        sat_en = d_accumulator_b ? ctrl_q[`CTL_SATB] : ctrl_q[`CTL_SATA];
  reg  [39:0] acc_res;
  always @* begin
    acc_res = sum[39:0];
    if (sat_en && cat_ov) begin
      acc_res = sum[40] ? 40'h8000000000 : 40'h7FFFFFFFFF;
    end else if (sat_en && ctrl_q[`CTL_SAT32] && (sum[39:31] != {9{sum[39]}})) begin
      acc_res = sum[39] ? 40'hFF80000000 : 40'h007FFFFFFF;
    end
  end
  wire        grd_res = acc_res[39:32] != {8{acc_res[39]}};
  wire        grd_a = accumulator_a[39:32] != {8{accumulator_a[39]}};
  wire        grd_b = accumulator_b[39:32] != {8{accumulator_b[39]}};
  // store path: rounding then saturation, the accumulator itself is untouched
  wire [39:0] st_acc = op_accumulator_b ? accumulator_b : accumulator_a;
  wire [15:0] st_lo = st_acc[15:0];
  wire        rnd_up = op_round && (ctrl_q[`CTL_CONV] ?
                 ((st_lo > 16'h8000) || ((st_lo == 16'h8000) && st_acc[16])) : st_lo[15]);
  wire [39:0] st_r = st_acc + (rnd_up ? 40'h0000010000 : 40'h0000000000);
  wire        st_big = ctrl_q[`CTL_STSAT] && (st_r[39:31] != {9{st_r[39]}});
  wire [15:0] st_word = st_big ? (st_r[39] ? 16'h8000 : 16'h7FFF) : st_r[31:16];
  ////////////////////////////////////////////////////////////////////////////
  // operation decode
  reg        pa_en, pa_byte, pb_en, pc_en, acc_we, rx, ry, wx, chk, use_y, shd_save, shd_rest, mis;
  reg [3:0]  pa_idx, pb_idx, pc_idx;
  reg [15:0] pa_dat, pb_dat, pc_dat, ea, ya, wdat;
  reg [1:0]  wbe;
  reg [1:0]  nstate;
  wire [7:0] rd_byte = rd_hi_q ? xr_rdata[15:8] : xr_rdata[7:0];
  always @* begin
    pa_en = 1'b0; pa_byte = op_byte; pa_idx = op_dst; pa_dat = op_lit;
    pb_en = 1'b0; pb_idx = op_src; pb_dat = 16'h0000;
    pc_en = 1'b0; pc_idx = op_src2; pc_dat = 16'h0000;
    acc_we = 1'b0; d_prod = 1'b0; d_load = 1'b0; d_accumulator_b = op_accumulator_b; d_sub = op_sub;
    rx = 1'b0; ry = 1'b0; wx = 1'b0; chk = 1'b0; use_y = 1'b0;
    ea = w[op_src]; ya = w[op_src2]; wdat = w[op_src]; wbe = 2'b11;
    shd_save = 1'b0; shd_rest = 1'b0; nstate = state_q; mis = 1'b0;
    case (state_q)
      S_IDLE: begin
        if (op_valid) begin
          case (op_code)
            `OP_LIT: begin pa_en = 1'b1; end
            `OP_LOAD: begin
              rx = 1'b1; chk = !op_byte;
              pb_en = op_postinc; pb_dat = pinc(w[op_src], step);
            end
            `OP_STORE: begin
              ea = w[op_dst]; wx = 1'b1; chk = !op_byte;
              if (op_byte) begin
                wdat = {w[op_src][7:0], w[op_src][7:0]};
                wbe = w[op_dst][0] ? 2'b10 : 2'b01;
              end
              pb_en = op_postinc; pb_idx = op_dst;
              pb_dat = ctrl_q[`CTL_BREVEN] ? rev16(rev16(w[op_dst]) + rev16(brev_mod_q))
                                           : pinc(w[op_dst], step);
            end
            `OP_PUSH, `OP_CALL: begin
              ea = sp; wx = 1'b1; chk = 1'b1;
              wdat = (op_code == `OP_CALL) ? op_lit : w[op_src];
              pb_en = 1'b1; pb_idx = `SP_IDX; pb_dat = sp + 16'h0002;
            end
            `OP_POP, `OP_RET: begin
              ea = sp - 16'h0002; rx = 1'b1; chk = 1'b1;
              pb_en = 1'b1; pb_idx = `SP_IDX; pb_dat = sp - 16'h0002;
            end
            `OP_LINK: begin
              ea = sp; wx = 1'b1; chk = 1'b1; wdat = fp;
              pa_en = 1'b1; pa_byte = 1'b0; pa_idx = `FP_IDX; pa_dat = sp + 16'h0002;
              pb_en = 1'b1; pb_idx = `SP_IDX; pb_dat = sp + 16'h0002 + op_lit;
            end
            `OP_UNLK: begin
              ea = fp - 16'h0002; rx = 1'b1; chk = 1'b1;
              pb_en = 1'b1; pb_idx = `SP_IDX; pb_dat = fp - 16'h0002;
            end
            `OP_MAC: begin
              rx = 1'b1; ry = 1'b1; chk = 1'b1; use_y = 1'b1;
              pb_en = op_postinc; pb_dat = pinc(w[op_src], 16'h0002);
              pc_en = op_postinc; pc_dat = pinc(w[op_src2], 16'h0002);
            end
            `OP_MPY: begin acc_we = 1'b1; d_prod = 1'b1; d_load = 1'b1; d_sub = 1'b0; end
            `OP_ADD: begin acc_we = 1'b1; end
            `OP_LAC: begin acc_we = 1'b1; d_load = 1'b1; d_sub = 1'b0; end
            `OP_ASTR: begin
              ea = w[op_dst]; wx = 1'b1; chk = 1'b1; wdat = st_word;
              pb_en = op_postinc; pb_idx = op_dst; pb_dat = pinc(w[op_dst], 16'h0002);
            end
            `OP_SSAV: begin shd_save = 1'b1; end
            default: begin shd_rest = 1'b1; end
          endcase
          mis = chk && (ea[0] || (use_y && ya[0]));
          if (mis) begin
            pa_en = 1'b0; pb_en = 1'b0; pc_en = 1'b0; wx = 1'b0; rx = 1'b0; ry = 1'b0;
          end
          if (rx) begin
            nstate = S_WAIT;
          end
        end
      end
      S_WAIT: begin
        nstate = S_TAKE;
      end
      S_TAKE: begin
        nstate = S_IDLE;
        d_accumulator_b = rd_accumulator_b_q; d_sub = rd_sub_q; d_prod = 1'b1;
        pa_idx = rd_dst_q; pa_byte = rd_byte_q;
        pa_dat = rd_byte_q ? {8'h00, rd_byte} : xr_rdata;
        case (rd_op_q)
          `OP_MAC: begin acc_we = 1'b1; end
          `OP_RET: begin pa_en = 1'b0; end
          `OP_UNLK: begin pa_en = 1'b1; pa_idx = `FP_IDX; pa_byte = 1'b0; end
          default: begin pa_en = 1'b1; end
        endcase
      end
      default: begin
        nstate = S_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // register bus
  reg         aw_got_q, w_got_q;
  reg  [7:0]  awaddr_q;
  reg  [31:0] wdata_q;
  reg  [3:0]  wstrb_q;
  assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire        wr_go = aw_got_q && w_got_q && !s_axi_bvalid;
  wire        w_win = (awaddr_q[7:6] == 2'b01);
  wire        wr_ok = (awaddr_q[1:0] == 2'b00) && (w_win || awaddr_q <= `DCD_ACCBHI_OFS);
  wire        bw_en = wr_go && w_win && wr_ok;
  wire        st_wr = wr_go && (awaddr_q == `DCD_STATUS_OFS) && wstrb_q[0];
  reg  [31:0] rd_d;
  reg         rd_ok;
  always @* begin
    rd_ok = 1'b1;
    rd_d = 32'h00000000;
    if (s_axi_araddr[1:0] != 2'b00) begin
      rd_ok = 1'b0;
    end else if (s_axi_araddr[7:6] == 2'b01) begin
      rd_d = {16'h0000, w[s_axi_araddr[5:2]]};
    end else begin
      case (s_axi_araddr)
        `DCD_CTRL_OFS:     rd_d = {16'h0000, ctrl_q};
        `DCD_STATUS_OFS:   rd_d = {26'h0000000, (state_q != S_IDLE), aerr_q, grd_b, grd_a, cat_b_q, cat_a_q};
        `DCD_MODSTART_OFS: rd_d = {16'h0000, mod_start_q};
        `DCD_MODEND_OFS:   rd_d = {16'h0000, mod_end_q};
        `DCD_BREVMOD_OFS:  rd_d = {16'h0000, brev_mod_q};
        `DCD_ACCALO_OFS:   rd_d = accumulator_a[31:0];
        `DCD_ACCAHI_OFS:   rd_d = {24'h000000, accumulator_a[39:32]};
        `DCD_ACCBLO_OFS:   rd_d = accumulator_b[31:0];
        `DCD_ACCBHI_OFS:   rd_d = {24'h000000, accumulator_b[39:32]};
        default:           rd_ok = 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // working registers, core ports ahead of the bus
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_w
      localparam integer GI = gi;
      localparam [3:0] IDX = GI[3:0];
      reg [15:0] r_q;
      if (gi < SHD_N) begin : g_s
        assign shd_w[gi] = shd_q[gi];
      end else begin : g_n
        assign shd_w[gi] = 16'h0000;
      end
      always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          r_q <= 16'h0000;
        end else if (pc_en && pc_idx == IDX) begin
          r_q <= pc_dat;
        end else if (pb_en && pb_idx == IDX) begin
          r_q <= pb_dat;
        end else if (pa_en && pa_idx == IDX) begin
          r_q <= pa_byte ? {r_q[15:8], pa_dat[7:0]} : pa_dat;
        end else if (shd_rest && gi < SHD_N) begin
          r_q <= shd_w[gi];
        end else if (bw_en && awaddr_q[5:2] == IDX) begin
          if (wstrb_q[0]) r_q[7:0] <= wdata_q[7:0];
          if (wstrb_q[1]) r_q[15:8] <= wdata_q[15:8];
        end
      end
      assign w[gi] = r_q;
    end
  endgenerate

  integer si;
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (si = 0; si < SHD_N; si = si + 1) shd_q[si] <= 16'h0000;
    end else if (shd_save) begin
      for (si = 0; si < SHD_N; si = si + 1) shd_q[si] <= w[si];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequential state
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= S_IDLE;
      ctrl_q <= `DCD_CTRL_RST;
      mod_start_q <= 16'h0000; mod_end_q <= 16'h0000; brev_mod_q <= 16'h0000;
      cat_a_q <= 1'b0; cat_b_q <= 1'b0; aerr_q <= 1'b0;
      accumulator_a <= 40'h0000000000; accumulator_b <= 40'h0000000000;
      rd_op_q <= 4'h0; rd_dst_q <= 4'h0; rd_byte_q <= 1'b0;
      rd_hi_q <= 1'b0; rd_accumulator_b_q <= 1'b0; rd_sub_q <= 1'b0;
      xr_en_q <= 1'b0; xr_addr_q <= 16'h0000; yr_en_q <= 1'b0; yr_addr_q <= 16'h0000;
      xw_en_q <= 1'b0; xw_addr_q <= 16'h0000; xw_data_q <= 16'h0000; xw_be_q <= 2'b00;
      ret_addr_q <= 16'h0000; addr_err_trap_q <= 1'b0; arith_err_trap_q <= 1'b0;
      aw_got_q <= 1'b0; w_got_q <= 1'b0; awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000; wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0; s_axi_bresp <= 2'b00;
      s_axi_rvalid <= 1'b0; s_axi_rresp <= 2'b00; s_axi_rdata <= 32'h00000000;
    end else begin
      state_q <= nstate;
      xr_en_q <= rx; yr_en_q <= ry; xw_en_q <= wx;
      if (rx) xr_addr_q <= {ea[15:1], 1'b0};
      if (ry) yr_addr_q <= ya;
      if (wx) begin
        xw_addr_q <= ea; xw_data_q <= wdat; xw_be_q <= wbe;
      end
      if (rx) begin
        rd_op_q <= op_code; rd_dst_q <= op_dst; rd_byte_q <= op_byte && (op_code == `OP_LOAD);
        rd_hi_q <= ea[0]; rd_accumulator_b_q <= op_accumulator_b; rd_sub_q <= op_sub;
      end
      if (in_take && rd_op_q == `OP_RET) ret_addr_q <= xr_rdata;
      addr_err_trap_q <= mis;
      if (acc_we) begin
        if (d_accumulator_b) accumulator_b <= acc_res;
        else accumulator_a <= acc_res;
      end
      arith_err_trap_q <= acc_we && ((cat_ov && ctrl_q[`CTL_CATTE]) || (grd_res && ctrl_q[`CTL_OVTE]));
      // sticky flags: a new event wins over a clear in the same cycle
      cat_a_q <= (acc_we && !d_accumulator_b && cat_ov) || (cat_a_q && !(st_wr && wdata_q[`ST_CATA]));
      cat_b_q <= (acc_we && d_accumulator_b && cat_ov) || (cat_b_q && !(st_wr && wdata_q[`ST_CATB]));
      aerr_q <= mis || (aerr_q && !(st_wr && wdata_q[`ST_AERR]));
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1; awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1; wdata_q <= s_axi_wdata; wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_got_q <= 1'b0; w_got_q <= 1'b0; s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
        case (awaddr_q)
          `DCD_CTRL_OFS: begin
            if (wstrb_q[0]) ctrl_q[7:0] <= wdata_q[7:0];
            if (wstrb_q[1]) ctrl_q[15:8] <= wdata_q[15:8];
          end
          `DCD_MODSTART_OFS: mod_start_q <= wdata_q[15:0];
          `DCD_MODEND_OFS:   mod_end_q <= wdata_q[15:0];
          `DCD_BREVMOD_OFS:  brev_mod_q <= wdata_q[15:0];
          default: begin end
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1; s_axi_rdata <= rd_d; s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: sim/dcd_mem.sv
`timescale 1ns/1ps
`default_nettype none
module dcd_mem (
  input  wire logic        sys_clk,
  input  wire logic        xr_en_q,
  input  wire logic [15:0] xr_addr_q,
  output var  logic [15:0] xr_rdata,
  input  wire logic        yr_en_q,
  input  wire logic [15:0] yr_addr_q,
  output var  logic [15:0] yr_rdata,
  input  wire logic        xw_en_q,
  input  wire logic [15:0] xw_addr_q,
  input  wire logic [15:0] xw_data_q,
  input  wire logic [1:0]  xw_be_q
);
  logic [15:0] m [0:32767];
  // idle read lines toggle so stale data never passes for a fresh answer
  always @(posedge sys_clk) begin
    xr_rdata <= xr_en_q ? m[xr_addr_q[15:1]] : ~xr_rdata;
    yr_rdata <= yr_en_q ? m[yr_addr_q[15:1]] : ~yr_rdata;
    if (xw_en_q && xw_be_q[0]) m[xw_addr_q[15:1]][7:0] <= xw_data_q[7:0];
    if (xw_en_q && xw_be_q[1]) m[xw_addr_q[15:1]][15:8] <= xw_data_q[15:8];
  end
endmodule
`default_nettype wire

// File: sim/dcd_core_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module dcd_chk (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        op_valid,
  input wire logic        op_ready,
  input wire logic        xr_en_q,
  input wire logic [15:0] xr_addr_q,
  input wire logic        yr_en_q,
  input wire logic [15:0] yr_addr_q,
  input wire logic        xw_en_q,
  input wire logic [15:0] xw_addr_q,
  input wire logic [1:0]  xw_be_q,
  input wire logic        addr_err_trap_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  xr_even_a:
    assert property (xr_en_q |-> !xr_addr_q[0]) else $error("odd x read address");
  yr_pair_a:
    assert property (yr_en_q |-> xr_en_q && !yr_addr_q[0]) else $error("y read without x read");
  rd_wait_a:
    assert property (xr_en_q |-> !op_ready ##1 !op_ready ##1 op_ready) else $error("read op timing");
  rd_cause_a:
    assert property (xr_en_q |-> $past(op_valid && op_ready)) else $error("read without op");
  wr_cause_a:
    assert property (xw_en_q |-> $past(op_valid && op_ready)) else $error("write without op");
  trap_cause_a:
    assert property (addr_err_trap_q |-> $past(op_valid && op_ready)) else $error("trap without op");
  trap_quiet_a:
    assert property (addr_err_trap_q |-> !xw_en_q && !xr_en_q && !yr_en_q) else $error("access on trap");
  word_even_a:
    assert property (xw_en_q && xw_be_q == 2'b11 |-> !xw_addr_q[0]) else $error("odd word write");
endmodule
bind dcd_core dcd_chk chk_u (.sys_clk, .rst, .op_valid, .op_ready, .xr_en_q, .xr_addr_q, .yr_en_q,
  .yr_addr_q, .xw_en_q, .xw_addr_q, .xw_be_q, .addr_err_trap_q);
`default_nettype wire

// File: sim/test_dsp_cpu_datapath.sv
`timescale 1ns/1ps
`default_nettype none
`include "dcd_regs.vh"
module test_dsp_cpu_datapath;
  logic        sys_clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, rv;
  logic [3:0]  s_axi_wstrb, op_code, op_dst, op_src, op_src2;
  logic        op_valid, op_byte, op_postinc, op_accumulator_b, op_sub, op_round;
  logic [5:0]  op_shift;
  logic [15:0] op_lit, wa, wd;
  logic [15:0] w [16];
  logic [39:0] acc;
  logic [1:0]  rr;
  wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, op_ready;
  wire logic   xr_en_q, yr_en_q, xw_en_q, addr_err_trap_q, arith_err_trap_q;
  wire logic [1:0]  s_axi_bresp, s_axi_rresp, xw_be_q;
  wire logic [31:0] s_axi_rdata;
  wire logic [15:0] xr_addr_q, xr_rdata, yr_addr_q, yr_rdata, xw_addr_q, xw_data_q, ret_addr_q;
  int errors, n_compared, ntrap, natrap;
  dcd_core dut_u (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .op_valid, .op_ready, .op_code, .op_dst, .op_src, .op_src2, .op_byte, .op_postinc,
    .op_accumulator_b, .op_sub, .op_round, .op_shift, .op_lit, .xr_en_q, .xr_addr_q, .xr_rdata, .yr_en_q,
    .yr_addr_q, .yr_rdata, .xw_en_q, .xw_addr_q, .xw_data_q, .xw_be_q, .ret_addr_q,
    .addr_err_trap_q, .arith_err_trap_q);
  dcd_mem mem_u (.sys_clk, .xr_en_q, .xr_addr_q, .xr_rdata, .yr_en_q, .yr_addr_q, .yr_rdata,
    .xw_en_q, .xw_addr_q, .xw_data_q, .xw_be_q);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (xw_en_q === 1'b1) {wa, wd} <= {xw_addr_q, xw_data_q};
    if (addr_err_trap_q === 1'b1) ntrap <= ntrap + 1;
    if (arith_err_trap_q === 1'b1) natrap <= natrap + 1;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [39:0] e, s);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  // ready is sampled at the falling edge, where it equals its value at the next rising edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d, output logic [1:0] r);
    logic ra, rw, rb;
    @(posedge sys_clk);
    {s_axi_awaddr, s_axi_wdata} <= {a, 16'h0000, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    forever begin
      @(negedge sys_clk);
      {ra, rw, rb, r} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
      @(posedge sys_clk);
      if (ra) s_axi_awvalid <= 1'b0;
      if (rw) s_axi_wvalid <= 1'b0;
      if (rb) break;
    end
    s_axi_bready <= 1'b0;
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [1:0] er, input logic [31:0] e);
    logic ra, rd;
    @(posedge sys_clk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    forever begin
      @(negedge sys_clk);
      {ra, rd, rv, rr} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
      @(posedge sys_clk);
      if (ra) s_axi_arvalid <= 1'b0;
      if (rd) break;
    end
    s_axi_rready <= 1'b0;
    chk(n, {6'h00, er, e}, {6'h00, rr, rv});
  endtask
  task automatic wreg(input logic [3:0] n, input logic [15:0] v);
    wr(`DCD_WREG_BASE + {2'b00, n, 2'b00}, v, rr);
    chk("wreg resp", 40'h0, {38'h0, rr});
    w[n] = v;
  endtask
  task automatic op(input logic [3:0] c, d, s, input logic b, p, input logic [5:0] sh);
    @(posedge sys_clk);
    {op_code, op_dst, op_src, op_byte, op_postinc, op_shift, op_valid} <= {c, d, s, b, p, sh, 1'b1};
    do @(posedge sys_clk); while (op_ready !== 1'b1);
    op_valid <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic wrap_up;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {rst, op_valid, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h40;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {48'h0, 4'hF};
    {op_code, op_dst, op_src, op_src2, op_byte, op_postinc, op_accumulator_b, op_sub, op_round} = 21'h0;
    {op_shift, op_lit} = 22'h0;
    void'($urandom(42687));
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    rchk("ctrl", `DCD_CTRL_OFS, 2'b00, 32'h0);
    rchk("unmapped", 8'h80, 2'b10, 32'h0);
    for (int n = 0; n < 16; n++) wreg(n[3:0], 16'($urandom));
    for (int n = 0; n < 16; n++) rchk("wreg", `DCD_WREG_BASE + 8'(4 * n), 2'b00, {16'h0, w[n]});
    wreg(`SP_IDX, 16'h0100);
    op(`OP_PUSH, 4'h0, 4'h1, 1'b0, 1'b0, 6'h00);
    chk("push addr", 40'h100, {24'h0, wa});
    chk("push data", {24'h0, w[1]}, {24'h0, wd});
    rchk("sp push", 8'h7C, 2'b00, 32'h0102);
    op(`OP_POP, 4'h2, 4'h0, 1'b0, 1'b0, 6'h00);
    w[2] = w[1];
    rchk("pop", 8'h48, 2'b00, {16'h0, w[2]});
    rchk("sp pop", 8'h7C, 2'b00, 32'h0100);
    op(`OP_PUSH, 4'h0, 4'h1, 1'b0, 1'b0, 6'h00);
    op(`OP_RET, 4'h0, 4'h0, 1'b0, 1'b0, 6'h00);
    chk("ret", {24'h0, w[1]}, {24'h0, ret_addr_q});
    wreg(4'h4, 16'h0101);
    op(`OP_LOAD, 4'h5, 4'h4, 1'b1, 1'b1, 6'h00);
    w[5][7:0] = w[1][15:8];
    rchk("byte load", 8'h54, 2'b00, {16'h0, w[5]});
    rchk("byte inc", 8'h50, 2'b00, 32'h0102);
    wreg(4'h4, 16'h0100);
    op(`OP_LOAD, 4'h6, 4'h4, 1'b0, 1'b1, 6'h00);
    rchk("word load", 8'h58, 2'b00, {16'h0, w[1]});
    rchk("word inc", 8'h50, 2'b00, 32'h0102);
    wreg(4'h4, 16'h0101);
    op(`OP_LOAD, 4'h7, 4'h4, 1'b0, 1'b1, 6'h00);
    chk("trap", 40'h1, 40'(ntrap));
    rchk("no update", 8'h5C, 2'b00, {16'h0, w[7]});
    rchk("no inc", 8'h50, 2'b00, 32'h0101);
    wreg(4'h8, 16'h7FFF);
    op(`OP_LAC, 4'h0, 4'h8, 1'b0, 1'b0, 6'h08);
    acc = {8'h00, w[8], 16'h0} << 8;
    rchk("acc hi", `DCD_ACCAHI_OFS, 2'b00, {24'h0, acc[39:32]});
    rchk("acc lo", `DCD_ACCALO_OFS, 2'b00, acc[31:0]);
    rchk("guard", `DCD_STATUS_OFS, 2'b00, 32'h14);
    wr(`DCD_CTRL_OFS, 16'h0040, rr);
    op(`OP_ADD, 4'h0, 4'h8, 1'b0, 1'b0, 6'h08);
    acc = acc + ({8'h00, w[8], 16'h0} << 8);
    rchk("add hi", `DCD_ACCAHI_OFS, 2'b00, {24'h0, acc[39:32]});
    rchk("add lo", `DCD_ACCALO_OFS, 2'b00, acc[31:0]);
    rchk("catastrophic", `DCD_STATUS_OFS, 2'b00, 32'h11);
    chk("arith trap", 40'h1, 40'(natrap));
    wrap_up;
  end
  initial begin
    #50us;
    errors++;
    wrap_up;
  end
endmodule
`default_nettype wire
